// ==== urm_pkg.sv ====
// package: register map, field layout and reset values of the mute/wakeup receiver
package urm_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_WAKE = 1;
  localparam int CTRL_WLEN = 2;
  localparam int CTRL_OVERSAMPLE = 3;
  localparam int CTRL_SINGLE_SAMPLE = 4;
  localparam int CTRL_MUTE = 5;
  localparam int CTRL_READY_IE = 6;
  localparam int CTRL_IDLE_IE = 7;
  localparam int CTRL_ADDR_LSB = 8;

  // ----------------------------------------
  // status register fields
  // ----------------------------------------
  localparam int STAT_READY = 0;
  localparam int STAT_IDLE = 1;
  localparam int STAT_FE = 2;
  localparam int STAT_ORE = 3;
  localparam int STAT_NF = 4;

  // ----------------------------------------
  // baud register fields and reset values
  // ----------------------------------------
  localparam int BAUD_FRAC_LSB = 0;
  localparam int BAUD_MANT_LSB = 4;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [3:0] NODE_ADDR_RESET = 4'h0;

  // ----------------------------------------
  // frame and sampling counts
  // ----------------------------------------
  localparam logic [3:0] FRAME_BITS_SHORT = 4'ha;
  localparam logic [3:0] FRAME_BITS_LONG = 4'hb;
  localparam logic [3:0] OS16_LAST = 4'hf;
  localparam logic [3:0] OS8_LAST = 4'h7;
  localparam logic [3:0] OS16_MID = 4'h8;
  localparam logic [3:0] OS8_MID = 4'h4;
  localparam logic [3:0] DATA_BITS_SHORT = 4'h8;
  localparam logic [3:0] DATA_BITS_LONG = 4'h9;

  // ----------------------------------------
  // receive state machine, gray along the frame
  // ----------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } urm_rx_st_t;

endpackage

// ==== urm_sync.sv ====
// two-flop synchroniser for the receive pin
`timescale 1ns/10ps
module urm_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic d_in,
  output logic q_out
);

  logic meta_ff;
  logic q_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_ff <= RESET_LEVEL;
      q_ff <= RESET_LEVEL;
    end else begin
      meta_ff <= d_in;
      q_ff <= meta_ff;
    end
  end

  assign q_out = q_ff;

endmodule // urm_sync

// ==== urm_baud.sv ====
// fractional baud divider producing the oversampling tick
`timescale 1ns/10ps
module urm_baud (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] mantissa,
  input wire logic [3:0] fraction,
  input wire logic eighth_mode,
  output logic tick
);

  logic [16:0] acc_ff;
  logic [16:0] nxt_acc;
  logic tick_ff;
  logic nxt_tick;
  logic [16:0] div16;
  logic [16:0] sum;

  // divider in sixteenths; 8x mode uses eighths only
  always_comb begin
    div16 = eighth_mode ? {1'b0, mantissa, fraction[2:0], 1'b0} : {1'b0, mantissa, fraction};
    sum = acc_ff + 17'h00010;
    nxt_acc = sum;
    nxt_tick = 1'b0;
    if (div16 == 17'h00000) begin
      nxt_acc = 17'h00000;
    end else if (sum >= div16) begin
      nxt_acc = sum - div16;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_ff <= 17'h00000;
      tick_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule // urm_baud

// ==== urm_top.sv ====
// receiver with mute mode, idle-line and address-mark wakeup
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module urm_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_pin,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic rx_irq,
  output logic rx_mute_ctrl,
  output logic rx_data_ready_flag
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    urm_pkg::urm_rx_st_t st;
    logic [3:0] samp;
    logic [3:0] bits;
    logic [3:0] idle_cnt;
    logic idle_armed;
    logic [2:0] votes;
    logic noise_acc;
    logic [8:0] shift;
    logic [8:0] data;
    logic en;
    logic wake;
    logic wlen;
    logic oversample_select;
    logic single_sample_select;
    logic mute;
    logic ready_ie;
    logic idle_ie;
    logic [3:0] node_addr;
    logic [15:0] baud;
    logic ready;
    logic idle;
    logic fe;
    logic ore;
    logic nf;
    logic [31:0] rdata;
    logic irq;
  } urm_regs_t;

  urm_regs_t state_ff;
  urm_regs_t nxt_state;
  logic rx_s;
  logic tick;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic urm_bit_value(input logic [2:0] v, input logic one);
    if (one) begin
      return v[1];
    end
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic urm_noisy(input logic [2:0] v, input logic one);
    return !one && (v != 3'b000) && (v != 3'b111);
  endfunction

  // ----------------------------------------
  // pin synchroniser and baud tick
  // ----------------------------------------
  urm_sync #(
    .RESET_LEVEL(1'b1)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d_in(rx_pin),
    .q_out(rx_s)
  );

  urm_baud u_baud (
    .clk(clk),
    .resetn(resetn),
    .mantissa(state_ff.baud[urm_pkg::BAUD_MANT_LSB +: 12]),
    .fraction(state_ff.baud[urm_pkg::BAUD_FRAC_LSB +: 4]),
    .eighth_mode(state_ff.oversample_select),
    .tick(tick)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [3:0] os_last;
  logic [3:0] os_mid;
  logic [3:0] frame_bits;
  logic [3:0] data_bits;
  logic bit_end;
  logic bit_val;
  logic char_done;
  logic char_fe;
  logic char_nf;
  logic [8:0] dchar;
  logic is_addr;
  logic addr_match;
  logic idle_evt;

  always_comb begin
    nxt_state = state_ff;
    os_last = state_ff.oversample_select ? urm_pkg::OS8_LAST : urm_pkg::OS16_LAST;
    os_mid = state_ff.oversample_select ? urm_pkg::OS8_MID : urm_pkg::OS16_MID;
    frame_bits = state_ff.wlen ? urm_pkg::FRAME_BITS_LONG : urm_pkg::FRAME_BITS_SHORT;
    data_bits = state_ff.wlen ? urm_pkg::DATA_BITS_LONG : urm_pkg::DATA_BITS_SHORT;
    bit_end = tick && (state_ff.samp == os_last);
    bit_val = urm_bit_value(state_ff.votes, state_ff.single_sample_select);
    char_done = 1'b0;
    char_fe = 1'b0;
    char_nf = 1'b0;
    idle_evt = 1'b0;
    dchar = state_ff.wlen ? state_ff.shift : {1'b0, state_ff.shift[8:1]};
    is_addr = state_ff.wlen ? dchar[8] : dchar[7];
    addr_match = (dchar[3:0] == state_ff.node_addr);

    // ----------------------------------------
    // sampling at the bit centre
    // ----------------------------------------
    if (tick && state_ff.st != urm_pkg::RX_IDLE) begin
      nxt_state.samp = bit_end ? 4'h0 : state_ff.samp + 4'h1;
      if (state_ff.samp == os_mid - 4'h1) begin
        nxt_state.votes[0] = rx_s;
      end
      if (state_ff.samp == os_mid) begin
        nxt_state.votes[1] = rx_s;
      end
      if (state_ff.samp == os_mid + 4'h1) begin
        nxt_state.votes[2] = rx_s;
      end
    end

    // ----------------------------------------
    // frame state machine
    // ----------------------------------------
    case (state_ff.st)
      urm_pkg::RX_IDLE: begin
        if (!rx_s) begin
          nxt_state.st = urm_pkg::RX_START;
          nxt_state.samp = 4'h0;
          nxt_state.idle_cnt = 4'h0;
          nxt_state.noise_acc = 1'b0;
        end else if (tick) begin
          // idle frame: all-ones for a whole frame length
          nxt_state.samp = (state_ff.samp == os_last) ? 4'h0 : state_ff.samp + 4'h1;
          if (state_ff.samp == os_last && state_ff.idle_cnt != frame_bits) begin
            nxt_state.idle_cnt = state_ff.idle_cnt + 4'h1;
            idle_evt = (state_ff.idle_cnt + 4'h1 == frame_bits);
          end
        end
      end
      urm_pkg::RX_START: begin
        if (bit_end) begin
          if (bit_val) begin
            nxt_state.st = urm_pkg::RX_IDLE;
          end else begin
            nxt_state.st = urm_pkg::RX_DATA;
            nxt_state.bits = 4'h0;
            nxt_state.noise_acc = urm_noisy(state_ff.votes, state_ff.single_sample_select);
          end
        end
      end
      urm_pkg::RX_DATA: begin
        if (bit_end) begin
          nxt_state.shift = {bit_val, state_ff.shift[8:1]};
          nxt_state.bits = state_ff.bits + 4'h1;
          if (urm_noisy(state_ff.votes, state_ff.single_sample_select)) begin
            nxt_state.noise_acc = 1'b1;
          end
          if (state_ff.bits + 4'h1 == data_bits) begin
            nxt_state.st = urm_pkg::RX_STOP;
          end
        end
      end
      urm_pkg::RX_STOP: begin
        if (bit_end) begin
          nxt_state.st = urm_pkg::RX_IDLE;
          nxt_state.idle_cnt = 4'h0;
          char_done = 1'b1;
          char_fe = !bit_val;
          char_nf = state_ff.noise_acc || urm_noisy(state_ff.votes, state_ff.single_sample_select);
        end
      end
      default: begin
        nxt_state.st = urm_pkg::RX_IDLE;
      end
    endcase

    if (!state_ff.en) begin
      nxt_state.st = urm_pkg::RX_IDLE;
      nxt_state.samp = 4'h0;
      nxt_state.idle_cnt = 4'h0;
      char_done = 1'b0;
      idle_evt = 1'b0;
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (wr) begin
      case (addr)
        urm_pkg::ADDR_CTRL: begin
          nxt_state.en = wdata[urm_pkg::CTRL_EN];
          nxt_state.wake = wdata[urm_pkg::CTRL_WAKE];
          nxt_state.wlen = wdata[urm_pkg::CTRL_WLEN];
          nxt_state.oversample_select = wdata[urm_pkg::CTRL_OVERSAMPLE];
          nxt_state.single_sample_select = wdata[urm_pkg::CTRL_SINGLE_SAMPLE];
          nxt_state.ready_ie = wdata[urm_pkg::CTRL_READY_IE];
          nxt_state.idle_ie = wdata[urm_pkg::CTRL_IDLE_IE];
          nxt_state.node_addr = wdata[urm_pkg::CTRL_ADDR_LSB +: 4];
          if (!state_ff.ready) begin
            nxt_state.mute = wdata[urm_pkg::CTRL_MUTE];
          end
        end
        urm_pkg::ADDR_BAUD: begin
          nxt_state.baud = wdata[15:0];
        end
        urm_pkg::ADDR_STAT: begin
          if (wdata[urm_pkg::STAT_IDLE]) begin
            nxt_state.idle = 1'b0;
          end
          if (wdata[urm_pkg::STAT_FE]) begin
            nxt_state.fe = 1'b0;
          end
          if (wdata[urm_pkg::STAT_ORE]) begin
            nxt_state.ore = 1'b0;
          end
          if (wdata[urm_pkg::STAT_NF]) begin
            nxt_state.nf = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (rd && addr == urm_pkg::ADDR_DATA) begin
      nxt_state.ready = 1'b0;
    end

    // ----------------------------------------
    // character and idle events, these win over clears
    // ----------------------------------------
    if (char_done) begin
      if (state_ff.mute) begin
        if (state_ff.wake && is_addr && addr_match) begin
          nxt_state.mute = 1'b0;
          nxt_state.data = dchar;
          nxt_state.ready = 1'b1;
          nxt_state.idle_armed = 1'b1;
        end
      end else if (state_ff.wake && is_addr && !addr_match) begin
        nxt_state.mute = 1'b1;
      end else begin
        nxt_state.idle_armed = 1'b1;
        if (state_ff.ready && nxt_state.ready) begin
          nxt_state.ore = 1'b1;
        end else begin
          nxt_state.data = dchar;
          nxt_state.ready = 1'b1;
          if (char_fe) begin
            nxt_state.fe = 1'b1;
          end
          if (char_nf) begin
            nxt_state.nf = 1'b1;
          end
        end
      end
    end
    if (idle_evt) begin
      if (state_ff.mute) begin
        if (!state_ff.wake) begin
          nxt_state.mute = 1'b0;
          nxt_state.idle_armed = 1'b0;
        end
      end else if (state_ff.idle_armed) begin
        nxt_state.idle = 1'b1;
        nxt_state.idle_armed = 1'b0;
      end
    end

    // ----------------------------------------
    // read data, one cycle after the strobe
    // ----------------------------------------
    nxt_state.rdata = 32'h00000000;
    if (rd) begin
      case (addr)
        urm_pkg::ADDR_CTRL: begin
          nxt_state.rdata[urm_pkg::CTRL_EN] = state_ff.en;
          nxt_state.rdata[urm_pkg::CTRL_WAKE] = state_ff.wake;
          nxt_state.rdata[urm_pkg::CTRL_WLEN] = state_ff.wlen;
          nxt_state.rdata[urm_pkg::CTRL_OVERSAMPLE] = state_ff.oversample_select;
          nxt_state.rdata[urm_pkg::CTRL_SINGLE_SAMPLE] = state_ff.single_sample_select;
          nxt_state.rdata[urm_pkg::CTRL_MUTE] = state_ff.mute;
          nxt_state.rdata[urm_pkg::CTRL_READY_IE] = state_ff.ready_ie;
          nxt_state.rdata[urm_pkg::CTRL_IDLE_IE] = state_ff.idle_ie;
          nxt_state.rdata[urm_pkg::CTRL_ADDR_LSB +: 4] = state_ff.node_addr;
        end
        urm_pkg::ADDR_BAUD: begin
          nxt_state.rdata[15:0] = state_ff.baud;
        end
        urm_pkg::ADDR_STAT: begin
          nxt_state.rdata[urm_pkg::STAT_READY] = state_ff.ready;
          nxt_state.rdata[urm_pkg::STAT_IDLE] = state_ff.idle;
          nxt_state.rdata[urm_pkg::STAT_FE] = state_ff.fe;
          nxt_state.rdata[urm_pkg::STAT_ORE] = state_ff.ore;
          nxt_state.rdata[urm_pkg::STAT_NF] = state_ff.nf;
        end
        urm_pkg::ADDR_DATA: begin
          nxt_state.rdata[8:0] = state_ff.data;
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // interrupt request, held off while muted
    // ----------------------------------------
    nxt_state.irq = !nxt_state.mute &&
      ((nxt_state.ready && nxt_state.ready_ie) || (nxt_state.idle && nxt_state.idle_ie));
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= '0;
      state_ff.st <= urm_pkg::RX_IDLE;
      state_ff.baud <= urm_pkg::BAUD_RESET;
      state_ff.node_addr <= urm_pkg::NODE_ADDR_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = state_ff.rdata;
  assign rx_irq = state_ff.irq;
  assign rx_mute_ctrl = state_ff.mute;
  assign rx_data_ready_flag = state_ff.ready;

endmodule // urm_top

// ==== urm_properties.sv ====
// checker: port-level properties of the mute/wakeup receiver
`timescale 1ns/10ps
module urm_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic rx_irq,
  input wire logic rx_mute_ctrl,
  input wire logic rx_data_ready_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_ctrl_wr;
    wr && addr == urm_pkg::ADDR_CTRL;
  endsequence
  sequence s_empty_ctrl_wr;
    s_ctrl_wr ##0 !rx_data_ready_flag;
  endsequence
  sequence s_full_data_rd;
    rd && addr == urm_pkg::ADDR_DATA ##0 rx_data_ready_flag;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_reset_quiet: assert property ($rose(resetn) |-> !rx_mute_ctrl && !rx_data_ready_flag && !rx_irq && rdata == 32'h0)
    else $error("outputs not cleared by reset");
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero without read");
  a_rd_unmapped: assert property (rd && addr > urm_pkg::ADDR_DATA |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_mute_no_irq: assert property (rx_mute_ctrl && $past(rx_mute_ctrl) |-> !rx_irq)
    else $error("interrupt raised while muted");
  a_mute_no_ready: assert property (rx_mute_ctrl |-> !$rose(rx_data_ready_flag))
    else $error("data ready set while muted");
  a_ready_read_clr: assert property (s_full_data_rd |=> !rx_data_ready_flag)
    else $error("data read did not clear ready");
  a_mute_sw_set: assert property (s_empty_ctrl_wr ##0 wdata[urm_pkg::CTRL_MUTE] |=> rx_mute_ctrl)
    else $error("mute write of one not taken");
  a_mute_sw_clr: assert property (s_empty_ctrl_wr ##0 !wdata[urm_pkg::CTRL_MUTE] |=> !rx_mute_ctrl)
    else $error("mute write of zero not taken");
  a_mute_sw_ign: assert property (s_ctrl_wr ##0 rx_data_ready_flag |=> $stable(rx_mute_ctrl))
    else $error("mute write taken while data ready");
endmodule // urm_properties

// ==== urm_node.sv ====
// far-side serial node driving the shared receive line
`timescale 1ns/10ps
module urm_node (
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;
  // ----------------------------------------
  // line drivers
  // ----------------------------------------
  task automatic hold(input logic lvl, input int nbits, input int cpb);
    @(posedge clk);
    line <= lvl;
    repeat (nbits * cpb - 1) @(posedge clk);
  endtask
  // exact bit period, no deviation added
  task automatic send_char(input logic [8:0] data, input logic long_word, input int cpb);
    hold(1'b0, 1, cpb);
    for (int i = 0; i < (long_word ? 9 : 8); i++) begin
      hold(data[i], 1, cpb);
    end
    hold(1'b1, 1, cpb);
  endtask
endmodule // urm_node

// ==== tb_top.sv ====
// testbench for the mute/wakeup receiver
`timescale 1ns/10ps
module tb_top;
  logic clk, resetn, rx_pin, wr, rd, rx_irq, rx_mute_ctrl, rx_data_ready_flag;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  urm_top u_dut (.clk(clk), .resetn(resetn), .rx_pin(rx_pin), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_irq(rx_irq), .rx_mute_ctrl(rx_mute_ctrl), .rx_data_ready_flag(rx_data_ready_flag));
  urm_node u_node (.clk(clk), .line(rx_pin));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus_rd(a, v);
    check(name, exp, v);
  endtask
  task automatic wait_ready(input int bound);
    for (int i = 0; i < bound && rx_data_ready_flag !== 1'b1; i++) @(negedge clk);
    check("ready", 32'h1, {31'h0, rx_data_ready_flag});
    @(negedge clk);
    check("irq", 32'h1, {31'h0, rx_irq});
  endtask
  task automatic quiet_check(input logic mute);
    repeat (20) @(negedge clk);
    check("ready", 32'h0, {31'h0, rx_data_ready_flag});
    check("irq", 32'h0, {31'h0, rx_irq});
    check("mute", {31'h0, mute}, {31'h0, rx_mute_ctrl});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    check("mute", 32'h0, {31'h0, rx_mute_ctrl});
    rd_check("ctrl", urm_pkg::ADDR_CTRL, 32'h0);
    rd_check("baud", urm_pkg::ADDR_BAUD, {16'h0, urm_pkg::BAUD_RESET});
    rd_check("unmapped", 8'h10, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_normal;
    bus_wr(urm_pkg::ADDR_BAUD, 32'h10);
    bus_wr(urm_pkg::ADDR_CTRL, 32'hc1);
    u_node.send_char(9'h0a5, 1'b0, 16);
    wait_ready(40);
    rd_check("data", urm_pkg::ADDR_DATA, 32'ha5);
    check("ready", 32'h0, {31'h0, rx_data_ready_flag});
    u_node.hold(1'b1, 12, 16);
    rd_check("stat", urm_pkg::ADDR_STAT, 32'h2);
    check("irq", 32'h1, {31'h0, rx_irq});
    bus_wr(urm_pkg::ADDR_STAT, 32'h1e);
    rd_check("stat", urm_pkg::ADDR_STAT, 32'h0);
    check("irq", 32'h0, {31'h0, rx_irq});
    $display("test normal done");
  endtask
  task automatic t_idle_mute;
    bus_wr(urm_pkg::ADDR_CTRL, 32'h61);
    check("mute", 32'h1, {31'h0, rx_mute_ctrl});
    u_node.send_char(9'h033, 1'b0, 16);
    quiet_check(1'b1);
    u_node.hold(1'b1, 12, 16);
    check("mute", 32'h0, {31'h0, rx_mute_ctrl});
    rd_check("stat", urm_pkg::ADDR_STAT, 32'h0);
    u_node.send_char(9'h03c, 1'b0, 16);
    wait_ready(40);
    bus_wr(urm_pkg::ADDR_CTRL, 32'h61);
    check("mute", 32'h0, {31'h0, rx_mute_ctrl});
    rd_check("data", urm_pkg::ADDR_DATA, 32'h3c);
    bus_wr(urm_pkg::ADDR_CTRL, 32'h61);
    rd_check("ctrl", urm_pkg::ADDR_CTRL, 32'h61);
    bus_wr(urm_pkg::ADDR_CTRL, 32'h41);
    check("mute", 32'h0, {31'h0, rx_mute_ctrl});
    $display("test idle mute done");
  endtask
  task automatic t_addr;
    bus_wr(urm_pkg::ADDR_CTRL, 32'h55f);
    u_node.send_char(9'h103, 1'b1, 8);
    quiet_check(1'b1);
    rd_check("ctrl", urm_pkg::ADDR_CTRL, 32'h57f);
    u_node.send_char(9'h0aa, 1'b1, 8);
    quiet_check(1'b1);
    u_node.send_char(9'h115, 1'b1, 8);
    wait_ready(40);
    check("mute", 32'h0, {31'h0, rx_mute_ctrl});
    rd_check("data", urm_pkg::ADDR_DATA, 32'h115);
    u_node.send_char(9'h077, 1'b1, 8);
    wait_ready(40);
    rd_check("data", urm_pkg::ADDR_DATA, 32'h77);
    $display("test address mark done");
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    t_reset();
    t_normal();
    t_idle_mute();
    t_addr();
    end_of_test();
  end
endmodule // tb_top
bind urm_top urm_properties u_props (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .rx_irq(rx_irq), .rx_mute_ctrl(rx_mute_ctrl), .rx_data_ready_flag(rx_data_ready_flag));
